// ===== design/bsc_pkg.sv
// bsc_pkg: constants and carriers for the serial port stop-collision and baud counter block
// assumes a 32-bit avalon-mm master with byte addresses and one 50 mhz system clock
package bsc_pkg;
	localparam int BSC_AW = 5;
	localparam logic [BSC_AW-1:0] BSC_OFF_RELOAD = 5'h00;
	localparam logic [BSC_AW-1:0] BSC_OFF_BUF = 5'h04;
	localparam logic [BSC_AW-1:0] BSC_OFF_CTRL = 5'h08;
	localparam logic [BSC_AW-1:0] BSC_OFF_STAT = 5'h0C;
	localparam logic [BSC_AW-1:0] BSC_OFF_IRQ_STAT = 5'h10;
	localparam logic [BSC_AW-1:0] BSC_OFF_IRQ_CLR = 5'h14;
	localparam logic [BSC_AW-1:0] BSC_OFF_IRQ_EN = 5'h18;
	// control register fields
	localparam int BSC_CTRL_EN = 0;
	localparam int BSC_CTRL_I2C = 1;
	localparam int BSC_CTRL_STOP = 2;
	// status register fields
	localparam int BSC_STAT_BUSY = 0;
	localparam int BSC_STAT_STOP_SEEN = 1;
	localparam int BSC_STAT_ACK = 2;
	localparam int BSC_STAT_WCOL = 3;
	// interrupt fields
	localparam int BSC_IRQ_DONE = 0;
	localparam int BSC_IRQ_COLL = 1;
	localparam int BSC_IRQ_W = 2;
	localparam logic [7:0] BSC_RELOAD_RST = 8'h09;
	localparam logic [2:0] BSC_CTRL_RST = 3'h0;
	localparam logic [3:0] BSC_I2C_BITS = 4'h9;
	localparam logic [3:0] BSC_SPI_BITS = 4'h8;

	typedef enum {
		BSC_IDLE, BSC_BIT_LOW, BSC_BIT_HIGH, BSC_SPI_LOW, BSC_SPI_HIGH,
		BSC_STOP_SDA, BSC_STOP_SCL, BSC_STOP_CNT, BSC_STOP_REL
	} bsc_state_e;

	typedef struct packed {
		logic read;
		logic write;
		logic [BSC_AW-1:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} bsc_av_req_s;

	typedef struct packed {
		logic sda;
		logic scl;
		logic miso;
	} bsc_pin_in_s;

	typedef struct packed {
		logic sda_out;
		logic sda_oe_n;
		logic scl_out;
		logic scl_oe_n;
		logic sck;
		logic mosi;
	} bsc_pin_out_s;
endpackage : bsc_pkg

// ===== design/bsc_top.sv
// bsc_top: serial port master with shared baud counter and stop-condition collision check
// assumes open-drain sda/scl resolved outside, pins asynchronous to clk_sys
// Summary of operation
// (R01) A stop request first drives sda low while scl is still held low after the ninth clock.
// (R02) The stop starts with sda low and scl is released at counter expiry once sda is sampled low.
// (R03) During a stop the baud counter is loaded as sda is driven low and, after scl is released, only once scl is sampled high.
// (R04) After sda is released in a stop, sda sampled low at counter expiry is a collision.
// (R05) After scl is sampled high in a stop, scl sampled low before sda goes high is a collision.
// (R06) A collision sets the collision flag and returns the port logic to idle.
// (R07) A collision aborting a stop releases sda and scl and clears the stop request.
// (R08) One baud counter times the serial clock in both i2c and spi master modes.
// (R09) The counter reloads from the software-writable reload register.
// (R10) A write to the shift buffer starts the counter.
// (R11) The counter stops when the operation ends and the clock pin keeps its level.
// (R12) The counter reloads twice per serial clock period.
// (R13) The reload conditions depend on the selected mode.
// (R14) Software must not use reload values 0x00 to 0x02 for i2c clocking.
`timescale 1ns/1ps
module bsc_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire bsc_pkg::bsc_av_req_s av_req,
	output logic [31:0] av_readdata,
	output logic av_waitrequest,
	input wire bsc_pkg::bsc_pin_in_s pin_in,
	output bsc_pkg::bsc_pin_out_s pin_out,
	output logic irq
);
	import bsc_pkg::*;

	bsc_state_e state;
	bsc_state_e next_state;
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [7:0] baud_reload_value;
	logic [7:0] shift_buffer;
	logic [2:0] ctrl;
	logic [3:0] bit_idx;
	logic [7:0] baud_counter;
	logic sda_drv;
	logic scl_drv;
	logic sck_q;
	logic stop_seen;
	logic ack_rx;
	logic wcol;
	logic [BSC_IRQ_W-1:0] irq_stat;
	logic [BSC_IRQ_W-1:0] irq_en;
	logic resp;
	logic [7:0] rd_mux;

	// synchronised pins: only sync2 is read by logic
	wire sda_s = sync2[2];
	wire scl_s = sync2[1];
	wire miso_s = sync2[0];

	// bus decode
	wire req = av_req.read | av_req.write;
	wire acc = req & resp;
	wire wr_lo = acc & av_req.write & av_req.byteenable[0];
	wire wr_reload = wr_lo & (av_req.address == BSC_OFF_RELOAD);
	wire wr_buf = wr_lo & (av_req.address == BSC_OFF_BUF);
	wire wr_ctrl = wr_lo & (av_req.address == BSC_OFF_CTRL);
	wire wr_clr = wr_lo & (av_req.address == BSC_OFF_IRQ_CLR);
	wire wr_en = wr_lo & (av_req.address == BSC_OFF_IRQ_EN);
	assign av_waitrequest = req & ~resp;

	wire enabled = ctrl[BSC_CTRL_EN];
	wire mode_i2c = ctrl[BSC_CTRL_I2C];
	wire idle = (state == BSC_IDLE);
	// a buffer write only starts a transfer from idle; otherwise it is a write collision
	wire start_ok = wr_buf & idle & enabled & ~ctrl[BSC_CTRL_STOP];
	wire wcol_set = wr_buf & ~start_ok;

	// baud counter expiry
	wire tick = (baud_counter == 8'h00);

	// state machine outputs
	logic load;
	logic coll;
	logic done;
	logic stop_done;
	logic next_sda_drv;
	logic next_scl_drv;
	logic next_sck;
	logic [3:0] next_bit_idx;
	logic [7:0] next_shift;
	logic next_ack;

	always_comb begin
		next_state = state;
		load = 1'b0;
		coll = 1'b0;
		done = 1'b0;
		stop_done = 1'b0;
		next_sda_drv = sda_drv;
		next_scl_drv = scl_drv;
		next_sck = sck_q;
		next_bit_idx = bit_idx;
		next_shift = shift_buffer;
		next_ack = ack_rx;
		case (state)
			BSC_IDLE: begin
				if (start_ok) begin // R10
					load = 1'b1; // R09
					next_bit_idx = 4'h0;
					next_shift = av_req.writedata[7:0];
					next_state = mode_i2c ? BSC_BIT_LOW : BSC_SPI_LOW; // R08
					if (mode_i2c) begin
						next_scl_drv = 1'b1;
						next_sda_drv = ~av_req.writedata[7];
					end else begin
						next_sda_drv = 1'b0;
					end
				end else if (enabled & mode_i2c & ctrl[BSC_CTRL_STOP]) begin
					next_sda_drv = 1'b1; // R01
					next_scl_drv = 1'b1; // R01
					load = 1'b1;
					next_state = BSC_STOP_SDA;
				end
			end
			BSC_BIT_LOW: begin
				if (tick) begin
					next_scl_drv = 1'b0;
					load = 1'b1; // R12
					next_state = BSC_BIT_HIGH;
				end
			end
			BSC_BIT_HIGH: begin
				// hold_cnt keeps the count until scl reads high, so a stretching slave is honoured
				if (tick & scl_s) begin
					next_scl_drv = 1'b1;
					load = 1'b1; // R12
					if (bit_idx == BSC_I2C_BITS - 4'h1) begin
						next_ack = ~sda_s;
						next_sda_drv = 1'b0;
						done = 1'b1;
						next_state = BSC_IDLE; // R11
					end else begin
						next_shift = {shift_buffer[6:0], sda_s};
						next_bit_idx = bit_idx + 4'h1;
						next_sda_drv = (bit_idx == BSC_I2C_BITS - 4'h2) ? 1'b0 : ~shift_buffer[6];
						next_state = BSC_BIT_LOW;
					end
				end
			end
			BSC_SPI_LOW: begin
				if (tick) begin
					next_sck = 1'b1;
					next_shift = {shift_buffer[6:0], miso_s};
					load = 1'b1; // R12
					next_state = BSC_SPI_HIGH;
				end
			end
			BSC_SPI_HIGH: begin
				if (tick) begin
					next_sck = 1'b0;
					next_bit_idx = bit_idx + 4'h1;
					if (bit_idx == BSC_SPI_BITS - 4'h1) begin
						done = 1'b1;
						next_state = BSC_IDLE; // R11
					end else begin
						load = 1'b1; // R12
						next_state = BSC_SPI_LOW;
					end
				end
			end
			BSC_STOP_SDA: begin
				if (tick & ~sda_s) begin
					next_scl_drv = 1'b0; // R02
					next_state = BSC_STOP_SCL;
				end
			end
			BSC_STOP_SCL: begin
				if (scl_s) begin
					load = 1'b1; // R03
					next_state = BSC_STOP_CNT;
				end
			end
			BSC_STOP_CNT: begin
				if (~scl_s) begin
					coll = 1'b1; // R05
				end else if (tick) begin
					next_sda_drv = 1'b0;
					load = 1'b1; // R12
					next_state = BSC_STOP_REL;
				end
			end
			BSC_STOP_REL: begin
				if (~scl_s & ~sda_s) begin
					coll = 1'b1; // R05
				end else if (tick) begin
					if (~sda_s) begin
						coll = 1'b1; // R04
					end else begin
						stop_done = 1'b1;
						done = 1'b1;
						next_state = BSC_IDLE;
					end
				end
			end
			default: begin
				next_state = BSC_IDLE;
			end
		endcase
		if (coll | ~enabled) begin
			next_sda_drv = 1'b0; // R07
			next_scl_drv = 1'b0; // R07
			next_state = BSC_IDLE; // R06
			load = 1'b0;
		end
	end

	// in i2c mode the low phase reloads freely, the high phase only once scl reads high
	wire hold_cnt = (state == BSC_BIT_HIGH) & ~scl_s; // R13

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 3'h7;
			sync2 <= 3'h7;
		end else if (clk_en) begin
			sync1 <= {pin_in.sda, pin_in.scl, pin_in.miso};
			sync2 <= sync1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			baud_counter <= 8'h00;
		end else if (clk_en) begin
			if (load) begin
				baud_counter <= baud_reload_value; // R09
			end else if (!tick && !idle && !hold_cnt) begin
				baud_counter <= baud_counter - 8'h01; // R08
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= BSC_IDLE;
			sda_drv <= 1'b0;
			scl_drv <= 1'b0;
			sck_q <= 1'b0;
			bit_idx <= 4'h0;
			shift_buffer <= 8'h00;
			ack_rx <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			sda_drv <= next_sda_drv;
			scl_drv <= next_scl_drv;
			sck_q <= next_sck; // R11
			bit_idx <= next_bit_idx;
			shift_buffer <= next_shift;
			ack_rx <= next_ack;
		end
	end

	// registers; hardware sets win over software clears
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			baud_reload_value <= BSC_RELOAD_RST;
			ctrl <= BSC_CTRL_RST;
			stop_seen <= 1'b0;
			wcol <= 1'b0;
			irq_stat <= '0;
			irq_en <= '0;
		end else if (clk_en) begin
			if (wr_reload) begin
				baud_reload_value <= av_req.writedata[7:0];
			end
			if (wr_ctrl) begin
				ctrl <= av_req.writedata[2:0];
			end
			if (stop_done | coll) begin
				ctrl[BSC_CTRL_STOP] <= 1'b0; // R07
			end
			if (start_ok | wr_ctrl) begin
				stop_seen <= 1'b0;
			end
			if (stop_done) begin
				stop_seen <= 1'b1;
			end
			if (wr_ctrl) begin
				wcol <= 1'b0;
			end
			if (wcol_set) begin
				wcol <= 1'b1;
			end
			if (wr_en) begin
				irq_en <= av_req.writedata[BSC_IRQ_W-1:0];
			end
			irq_stat <= (irq_stat & ~(wr_clr ? av_req.writedata[BSC_IRQ_W-1:0] : '0))
				| {coll, done}; // R06
		end
	end

	always_comb begin
		case (av_req.address)
			BSC_OFF_RELOAD: rd_mux = baud_reload_value;
			BSC_OFF_BUF: rd_mux = shift_buffer;
			BSC_OFF_CTRL: rd_mux = {5'h00, ctrl};
			BSC_OFF_STAT: rd_mux = {4'h0, wcol, ack_rx, stop_seen, ~idle};
			BSC_OFF_IRQ_STAT: rd_mux = {6'h00, irq_stat};
			BSC_OFF_IRQ_EN: rd_mux = {6'h00, irq_en};
			default: rd_mux = 8'h00;
		endcase
	end

	// fixed one wait state: answer registered in the first request cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			resp <= 1'b0;
			av_readdata <= 32'h0000_0000;
		end else if (clk_en) begin
			resp <= req & ~resp;
			if (req & ~resp) begin
				av_readdata <= {24'h00_0000, rd_mux};
			end
		end
	end

	assign irq = |(irq_stat & irq_en);
	assign pin_out.sda_out = 1'b0;
	assign pin_out.sda_oe_n = ~sda_drv;
	assign pin_out.scl_out = 1'b0;
	assign pin_out.scl_oe_n = ~scl_drv;
	assign pin_out.sck = sck_q;
	assign pin_out.mosi = shift_buffer[7];
endmodule : bsc_top

// ===== verif/bsc_top_chk.sv
// bsc_chk: port-level checks on bsc_top
// assumes open-drain pins resolved outside
`timescale 1ns/1ps
module bsc_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire bsc_pkg::bsc_av_req_s av_req,
	input wire logic [31:0] av_readdata,
	input wire logic av_waitrequest,
	input wire bsc_pkg::bsc_pin_out_s pin_out,
	input wire logic irq
);
	import bsc_pkg::*;
	wire req = av_req.read | av_req.write;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	one_wait_a: assert property (req && av_waitrequest && clk_en |=> !av_waitrequest)
		else $error("wait state not one cycle");
	idle_nowait_a: assert property (!req |-> !av_waitrequest)
		else $error("waitrequest without request");
	rd_upper_a: assert property (av_req.read && !av_waitrequest |-> av_readdata[31:8] == '0)
		else $error("read data upper bits set");
	sda_pull_a: assert property ($fell(pin_out.sda_oe_n) |-> !pin_out.scl_oe_n)
		else $error("sda pulled while scl free");
	scl_free_a: assert property ($rose(pin_out.scl_oe_n) |-> $stable(pin_out.sda_oe_n))
		else $error("sda moved as scl freed");
	count_first_a: assert property ($rose(pin_out.sda_oe_n) && pin_out.scl_oe_n
		&& !$rose(pin_out.scl_oe_n) |-> $past(pin_out.scl_oe_n, 3))
		else $error("sda freed without scl high count");
	irq_pins_a: assert property ($rose(irq) |-> pin_out.sda_oe_n && pin_out.scl_oe_n)
		else $error("collision left pins pulled");
	open_drain_a: assert property (!pin_out.sda_out && !pin_out.scl_out)
		else $error("open-drain data not low");
	cover property ($rose(irq));
	cover property ($fell(pin_out.sck));
	cover property ($rose(pin_out.sda_oe_n) && pin_out.scl_oe_n);
endmodule : bsc_chk
bind bsc_top bsc_chk u_bsc_chk (.clk_sys, .rst_n, .clk_en, .av_req, .av_readdata,
	.av_waitrequest, .pin_out, .irq);

// ===== verif/bsc_bus.sv
// bsc_bus: pull-ups, another master and an spi slave
// assumes the bench steers the other master
`timescale 1ns/1ps
module bsc_bus (
	input wire logic clk_sys,
	input wire bsc_pkg::bsc_pin_out_s pin_out,
	input wire logic sda_pull,
	input wire logic scl_pull,
	input wire logic [3:0] stretch,
	output bsc_pkg::bsc_pin_in_s pin_in
);
	import bsc_pkg::*;
	logic [3:0] hold = 4'h0;
	logic [7:0] sr = 8'hA5;
	logic sck_d = 1'b0;
	// wired-and with pull-ups, so a freed line reads high
	assign pin_in.sda = pin_out.sda_oe_n & ~sda_pull;
	assign pin_in.scl = pin_out.scl_oe_n & ~scl_pull & (hold == 4'h0);
	assign pin_in.miso = sr[7];
	// slow answer: stretch scl after the master frees it
	always @(posedge clk_sys) begin
		sck_d <= pin_out.sck;
		if (!pin_out.scl_oe_n) begin
			hold <= stretch;
		end else if (hold != 4'h0) begin
			hold <= hold - 4'h1;
		end
		if (sck_d && !pin_out.sck) begin
			sr <= {sr[6:0], sr[7]};
		end
	end
endmodule : bsc_bus

// ===== verif/tb.sv
// tb: bus access, spi timing, stop and its collisions
// assumes bsc_bus on the pins and bsc_chk bound
`timescale 1ns/1ps
module tb;
	import bsc_pkg::*;
	logic clk_sys = 0;
	logic rst_n = 0;
	logic clk_en = 1;
	bsc_av_req_s av_req = '0;
	logic [31:0] av_readdata;
	logic av_waitrequest;
	bsc_pin_in_s pin_in;
	bsc_pin_out_s pin_out;
	logic irq;
	logic sda_pull = 0;
	logic scl_pull = 0;
	logic [3:0] stretch = 4'h0;
	logic [7:0] q[$];
	int n_fail = 0;
	int samples_checked = 0;
	int ha, hb, k;
	always #10 clk_sys = ~clk_sys;
	bsc_top u_bsc_top (.clk_sys, .rst_n, .clk_en, .av_req, .av_readdata, .av_waitrequest,
		.pin_in, .pin_out, .irq);
	bsc_bus u_bsc_bus (.clk_sys, .pin_out, .sda_pull, .scl_pull, .stretch, .pin_in);
	task tally_and_finish;
		if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: exp %h got %h", $time, e, g);
		end
	endtask : chk
	task stall;
		n_fail++;
		tally_and_finish();
	endtask : stall
	task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
		int i;
		@(posedge clk_sys);
		av_req <= '{!w, w, a, 4'hF, {24'h0, d}};
		for (i = 0; i < 50; i++) begin
			@(posedge clk_sys);
			if (!av_waitrequest) break;
		end
		av_req <= '0;
		if (i == 50) stall();
	endtask : acc
	task rd(input logic [4:0] a, input logic [7:0] e);
		q.push_back(e);
		acc(0, a, 8'h00);
	endtask : rd
	task ck_irq(input logic e);
		@(posedge clk_sys);
		chk(e, irq);
	endtask : ck_irq
	// read data stand only in the cycle waitrequest is low
	always @(posedge clk_sys) begin
		if (av_req.read && !av_waitrequest && q.size() > 0) chk({24'h0, q.pop_front()}, av_readdata);
	end
	task automatic await(input logic scl_hi);
		int i = 0;
		while (i < 400 && pin_out.sda_oe_n) begin
			@(posedge clk_sys);
			i++;
		end
		while (i < 400 && !(pin_out.scl_oe_n && (scl_hi ? pin_in.scl : pin_out.sda_oe_n))) begin
			@(posedge clk_sys);
			i++;
		end
		if (i >= 400) stall();
	endtask : await
	task automatic spi(input logic [7:0] rl, output int hi);
		int lo = 0;
		int n = 0;
		int f = 0;
		logic ps = 1'b0;
		logic pm = 1'b0;
		logic [7:0] rx = 8'h00;
		logic [7:0] tx = 8'($urandom);
		hi = 0;
		acc(1, BSC_OFF_RELOAD, rl);
		acc(1, BSC_OFF_BUF, tx);
		for (int j = 0; j < 4000 && f < 8; j++) begin
			@(posedge clk_sys);
			if (pin_out.sck && !ps) begin
				// mosi moves with the rising sck, so take the level seen just before it
				rx = {rx[6:0], pm};
				n++;
			end
			if (!pin_out.sck && ps) f++;
			if (n > 0 && f < 8 && pin_out.sck) hi++;
			if (n > 0 && f < 8 && !pin_out.sck) lo++;
			ps = pin_out.sck;
			pm = pin_out.mosi;
		end
		if (f < 8) stall();
		chk(tx, rx);
		chk(lo * 8, hi * 7);
		repeat (20) begin
			@(posedge clk_sys);
			if (pin_out.sck) f++;
		end
		chk(8, f);
		rd(BSC_OFF_BUF, 8'hA5);
		hi = hi / 8;
	endtask : spi
	task automatic i2c_byte(input logic [7:0] d);
		int r = 0;
		logic ps = 1'b0;
		logic [8:0] rx = 9'h000;
		acc(1, BSC_OFF_BUF, d);
		acc(1, BSC_OFF_BUF, 8'h00);
		clk_en <= 1'b0;
		repeat (20) @(posedge clk_sys);
		chk(0, pin_out.scl_oe_n);
		clk_en <= 1'b1;
		for (int j = 0; j < 4000 && r < 9; j++) begin
			@(posedge clk_sys);
			if (pin_out.scl_oe_n && !ps) begin
				rx = {rx[7:0], pin_out.sda_oe_n};
				r++;
			end
			ps = pin_out.scl_oe_n;
		end
		if (r < 9) stall();
		chk({d, 1'b1}, rx);
		repeat (40) @(posedge clk_sys);
		rd(BSC_OFF_BUF, d);
		rd(BSC_OFF_STAT, 8'h08);
	endtask : i2c_byte
	initial begin
		k = $urandom(32'hC51E);
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(BSC_OFF_RELOAD, 8'h09);
		rd(5'h1C, 8'h00);
		k = $urandom_range(255, 3);
		acc(1, BSC_OFF_RELOAD, 8'(k));
		rd(BSC_OFF_RELOAD, 8'(k));
		acc(1, BSC_OFF_CTRL, 8'h01);
		spi(8'h04, ha);
		spi(8'h09, hb);
		chk(5, hb - ha);
		acc(1, BSC_OFF_CTRL, 8'h03);
		i2c_byte(8'($urandom));
		acc(1, BSC_OFF_IRQ_EN, 8'h02);
		stretch <= 4'($urandom_range(7, 0));
		acc(1, BSC_OFF_CTRL, 8'h07);
		await(0);
		repeat (40) @(posedge clk_sys);
		rd(BSC_OFF_STAT, 8'h02);
		rd(BSC_OFF_IRQ_STAT, 8'h01);
		ck_irq(0);
		acc(1, BSC_OFF_IRQ_CLR, 8'h03);
		sda_pull <= 1'b1;
		acc(1, BSC_OFF_CTRL, 8'h07);
		await(0);
		repeat (40) @(posedge clk_sys);
		ck_irq(1);
		rd(BSC_OFF_CTRL, 8'h03);
		rd(BSC_OFF_IRQ_STAT, 8'h02);
		sda_pull <= 1'b0;
		acc(1, BSC_OFF_IRQ_CLR, 8'h02);
		ck_irq(0);
		acc(1, BSC_OFF_IRQ_EN, 8'h00);
		acc(1, BSC_OFF_CTRL, 8'h07);
		await(1);
		repeat (3) @(posedge clk_sys);
		scl_pull <= 1'b1;
		await(0);
		scl_pull <= 1'b0;
		ck_irq(0);
		rd(BSC_OFF_IRQ_STAT, 8'h02);
		rd(BSC_OFF_CTRL, 8'h03);
		acc(1, BSC_OFF_IRQ_EN, 8'h02);
		ck_irq(1);
		acc(1, BSC_OFF_IRQ_CLR, 8'h02);
		ck_irq(0);
		tally_and_finish();
	end
endmodule : tb
